// ==== hw/dcsp_regs.vh ====
// register ports, control bit positions, reset values and counts of the serial port
`ifndef DCSP_REGS_VH
`define DCSP_REGS_VH

// i/o port numbers decoded from the three low address lines
`define DCSP_PORT_W 3
`define DCSP_PORT_CTL_LO 3'h0
`define DCSP_PORT_CTL_HI 3'h1

// data widths
`define DCSP_DATA_W 16
`define DCSP_WORD_W 8
`define DCSP_BITS_PER_WORD 4'h8
`define DCSP_BITCNT_W 4
`define DCSP_RX_LAST 4'h1

// lower control register bits
`define DCSP_LO_RX_FLAG 1
`define DCSP_LO_TX_FLAG 2
`define DCSP_LO_RX_IEN 3
`define DCSP_LO_TX_IEN 4
`define DCSP_LO_EXT_FRAMING 5
`define DCSP_LO_BCLK_OUT 6
`define DCSP_LO_LONG_PULSE 7
`define DCSP_LO_HI_SEL 8
`define DCSP_LO_FIFO_FULL 9
`define DCSP_LO_FIFO_EMPTY 10
`define DCSP_LO_TX_BUSY 11
`define DCSP_LO_RX_BUSY 12

// upper control register fields
`define DCSP_HI_FRATE_LSB 0
`define DCSP_HI_FRATE_MSB 7
`define DCSP_HI_BDIV_LSB 8
`define DCSP_HI_BDIV_MSB 11
`define DCSP_FRATE_W 8
`define DCSP_BDIV_W 4

// reset values
`define DCSP_CTL_LO_RST 16'h0000
`define DCSP_CTL_HI_RST 16'h0000
`define DCSP_ZERO16 16'h0000
`define DCSP_ZERO8 8'h00

// transmit queue depth: two entries, one pointer bit
`define DCSP_FIFO_CNT_W 2
`define DCSP_FIFO_DEPTH 2'h2

`endif

// ==== hw/dcsp_top.v ====
// dual channel codec serial port with i/o mapped control and data ports
//
// What this block does
// - two receive channels each shift their own input into their own receive register
// - internal framing starts transmit and receive together on a high frame pulse
// - frame pulse is short or long, chosen by software
// - frame pulse rate is the bit clock divided by the eight bit frame rate field plus one
// - external source holds receive frame low for a word; falling edge starts receive
// - rising receive frame edge sets the receive flag and interrupts if enabled
// - external source holds transmit frame low for a word; falling edge starts transmit
// - rising transmit frame edge sets the transmit flag and interrupts if enabled
// - software chooses the bit clock pin as input or as driven output
// - driven bit clock is the system clock divided by two times (a four bit field plus one)
// - reset releases the bit clock pin
// - without a running bit clock no transfer makes progress
// - receive data holds one eight bit sample per channel, transmit data two, reached by i/o ports
// - a control bit selects internal or external framing
// - port 0 reaches the lower control register
// - port 1 reaches the upper control register and the channel data registers
// - the port is decoded from the three low address lines
// - receive and transmit run at the same time without interference
// - the frame pulse can serve as a periodic sample clock or timer tick
// - transmit data registers form a queue feeding the transmit shift registers
// - each channel has an eight bit receive shift register ahead of its receive register
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ns
`include "dcsp_regs.vh"
`default_nettype none

module dcsp_top (
  // clock and reset
  input wire CLOCK,
  input wire RESETN,
  // register port
  input wire [`DCSP_PORT_W-1:0] ADDR,
  input wire [`DCSP_DATA_W-1:0] WDATA,
  input wire WR_STB,
  input wire RD_STB,
  output reg [`DCSP_DATA_W-1:0] RDATA,
  // serial data pins
  input wire RX_DATA_IN_CH0,
  input wire RX_DATA_IN_CH1,
  output reg TX_DATA_OUT_CH0,
  output reg TX_DATA_OUT_CH1,
  output reg TX_DATA_OE_CH0,
  output reg TX_DATA_OE_CH1,
  // framing pins
  output reg INTERNAL_FRAME_PULSE,
  input wire EXT_RX_FRAME_N,
  input wire EXT_TX_FRAME_N,
  // bit clock pin
  input wire BIT_CLOCK_IN,
  output reg BIT_CLOCK_OUT,
  output reg BIT_CLOCK_OE,
  // interrupt request
  output reg IRQ
);

  // falling edge of a sampled active low frame input
  function frame_fall;
    input prev;
    input cur;
    begin
      frame_fall = prev & ~cur;
    end
  endfunction

  // rising edge of a sampled active low frame input
  function frame_rise;
    input prev;
    input cur;
    begin
      frame_rise = ~prev & cur;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // control registers and port decode

  reg [`DCSP_DATA_W-1:0] ctl_lo_r;
  reg [`DCSP_DATA_W-1:0] ctl_hi_r;
  reg rx_flag_r;
  reg tx_flag_r;
  wire ext_framing;
  wire bclk_out_mode;
  wire long_pulse;
  wire hi_sel;
  wire [`DCSP_FRATE_W-1:0] frame_rate_divider;
  wire [`DCSP_BDIV_W-1:0] bit_clock_divider;
  wire wr_lo;
  wire wr_hi;
  wire wr_data;
  wire rd_data;
  reg rx_flag_set;
  reg tx_flag_set;

  // port decoded from the three low address lines
  assign wr_lo = WR_STB & (ADDR == `DCSP_PORT_CTL_LO);
  assign wr_hi = WR_STB & (ADDR == `DCSP_PORT_CTL_HI) & hi_sel;
  assign wr_data = WR_STB & (ADDR == `DCSP_PORT_CTL_HI) & ~hi_sel;
  assign rd_data = RD_STB & (ADDR == `DCSP_PORT_CTL_HI) & ~hi_sel;

  assign ext_framing = ctl_lo_r[`DCSP_LO_EXT_FRAMING];
  assign bclk_out_mode = ctl_lo_r[`DCSP_LO_BCLK_OUT];
  assign long_pulse = ctl_lo_r[`DCSP_LO_LONG_PULSE];
  assign hi_sel = ctl_lo_r[`DCSP_LO_HI_SEL];
  assign frame_rate_divider = ctl_hi_r[`DCSP_HI_FRATE_MSB:`DCSP_HI_FRATE_LSB];
  assign bit_clock_divider = ctl_hi_r[`DCSP_HI_BDIV_MSB:`DCSP_HI_BDIV_LSB];

  // control storage; flags are kept apart so a set beats a write-one clear
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ctl_lo_r <= `DCSP_CTL_LO_RST;
      ctl_hi_r <= `DCSP_CTL_HI_RST;
      rx_flag_r <= 1'b0;
      tx_flag_r <= 1'b0;
    end else begin
      if (wr_lo) begin
        ctl_lo_r <= WDATA;
      end
      if (wr_hi) begin
        ctl_hi_r <= WDATA;
      end
      rx_flag_r <= rx_flag_set | (rx_flag_r & ~(wr_lo & WDATA[`DCSP_LO_RX_FLAG]));
      tx_flag_r <= tx_flag_set | (tx_flag_r & ~(wr_lo & WDATA[`DCSP_LO_TX_FLAG]));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bit clock: driven from the system clock or taken from the pin

  reg [`DCSP_BDIV_W-1:0] bdiv_cnt_r;
  reg bclk_int_r;
  reg bclk_s1_r;
  reg bclk_s2_r;
  reg bclk_s3_r;
  wire bdiv_hit;
  reg bclk_rise;
  reg bclk_fall;

  assign bdiv_hit = (bdiv_cnt_r == bit_clock_divider);

  // half period of the driven clock is divider plus one system clocks
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      bdiv_cnt_r <= {`DCSP_BDIV_W{1'b0}};
      bclk_int_r <= 1'b0;
      BIT_CLOCK_OUT <= 1'b0;
      BIT_CLOCK_OE <= 1'b0;
    end else begin
      BIT_CLOCK_OE <= bclk_out_mode;
      if (!bclk_out_mode) begin
        bdiv_cnt_r <= {`DCSP_BDIV_W{1'b0}};
        bclk_int_r <= 1'b0;
        BIT_CLOCK_OUT <= 1'b0;
      end else if (bdiv_hit) begin
        bdiv_cnt_r <= {`DCSP_BDIV_W{1'b0}};
        bclk_int_r <= ~bclk_int_r;
        BIT_CLOCK_OUT <= ~bclk_int_r;
      end else begin
        bdiv_cnt_r <= bdiv_cnt_r + 1'b1;
      end
    end
  end

  // external clock through two flip-flops, third stage for edge detect;
  // reset high so a released, idle-high pin gives no false rise after reset
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      bclk_s1_r <= 1'b1;
      bclk_s2_r <= 1'b1;
      bclk_s3_r <= 1'b1;
    end else begin
      bclk_s1_r <= BIT_CLOCK_IN;
      bclk_s2_r <= bclk_s1_r;
      bclk_s3_r <= bclk_s2_r;
    end
  end

  // one cycle enables on bit clock edges; no edges means no progress
  always @* begin
    if (bclk_out_mode) begin
      bclk_rise = bdiv_hit & ~bclk_int_r;
      bclk_fall = bdiv_hit & bclk_int_r;
    end else begin
      bclk_rise = bclk_s2_r & ~bclk_s3_r;
      bclk_fall = ~bclk_s2_r & bclk_s3_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers for serial data and frame inputs

  reg [1:0] dr_s1_r;
  reg [1:0] dr_s2_r;
  reg fsr_s1_r;
  reg fsr_s2_r;
  reg fsx_s1_r;
  reg fsx_s2_r;
  reg fsr_q_r;
  reg fsx_q_r;

  // two flip-flops on every pin, then frame levels sampled on bit clock rise
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      dr_s1_r <= 2'h0;
      dr_s2_r <= 2'h0;
      fsr_s1_r <= 1'b1;
      fsr_s2_r <= 1'b1;
      fsx_s1_r <= 1'b1;
      fsx_s2_r <= 1'b1;
      fsr_q_r <= 1'b1;
      fsx_q_r <= 1'b1;
    end else begin
      dr_s1_r <= {RX_DATA_IN_CH1, RX_DATA_IN_CH0};
      dr_s2_r <= dr_s1_r;
      fsr_s1_r <= EXT_RX_FRAME_N;
      fsr_s2_r <= fsr_s1_r;
      fsx_s1_r <= EXT_TX_FRAME_N;
      fsx_s2_r <= fsx_s1_r;
      if (bclk_rise) begin
        fsr_q_r <= fsr_s2_r;
        fsx_q_r <= fsx_s2_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // internal frame pulse generator

  reg [`DCSP_FRATE_W-1:0] frame_cnt_r;
  reg [`DCSP_BITCNT_W-1:0] pulse_cnt_r;
  wire int_start;

  // a frame starts each frame_rate_divider+1 bit clocks
  assign int_start = bclk_rise & ~ext_framing & (frame_cnt_r == `DCSP_ZERO8);

  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      frame_cnt_r <= `DCSP_ZERO8;
      pulse_cnt_r <= {`DCSP_BITCNT_W{1'b0}};
      INTERNAL_FRAME_PULSE <= 1'b0;
    end else if (ext_framing) begin
      frame_cnt_r <= `DCSP_ZERO8;
      pulse_cnt_r <= {`DCSP_BITCNT_W{1'b0}};
      INTERNAL_FRAME_PULSE <= 1'b0;
    end else if (bclk_rise) begin
      if (int_start) begin
        frame_cnt_r <= frame_rate_divider;
        INTERNAL_FRAME_PULSE <= 1'b1;
        pulse_cnt_r <= long_pulse ? `DCSP_BITS_PER_WORD - 1'b1 : {`DCSP_BITCNT_W{1'b0}};
      end else begin
        frame_cnt_r <= frame_cnt_r - 1'b1;
        if (pulse_cnt_r != {`DCSP_BITCNT_W{1'b0}}) begin
          pulse_cnt_r <= pulse_cnt_r - 1'b1;
        end else begin
          INTERNAL_FRAME_PULSE <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit queue of two channel pairs

  reg [`DCSP_DATA_W-1:0] tx_holding_regs [0:1];
  reg fifo_wp_r;
  reg fifo_rp_r;
  reg [`DCSP_FIFO_CNT_W-1:0] fifo_cnt_r;
  wire fifo_full;
  wire fifo_empty;
  wire fifo_push;
  wire fifo_pop;
  wire tx_start;

  assign fifo_full = (fifo_cnt_r == `DCSP_FIFO_DEPTH);
  assign fifo_empty = (fifo_cnt_r == {`DCSP_FIFO_CNT_W{1'b0}});
  assign fifo_push = wr_data & ~fifo_full;
  assign fifo_pop = tx_start & ~fifo_empty;

  // low byte for channel 0, high byte for channel 1; writes when full are dropped
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      tx_holding_regs[0] <= `DCSP_ZERO16;
      tx_holding_regs[1] <= `DCSP_ZERO16;
      fifo_wp_r <= 1'b0;
      fifo_rp_r <= 1'b0;
      fifo_cnt_r <= {`DCSP_FIFO_CNT_W{1'b0}};
    end else begin
      if (fifo_push) begin
        tx_holding_regs[fifo_wp_r] <= WDATA;
        fifo_wp_r <= ~fifo_wp_r;
      end
      if (fifo_pop) begin
        fifo_rp_r <= ~fifo_rp_r;
      end
      if (fifo_push & ~fifo_pop) begin
        fifo_cnt_r <= fifo_cnt_r + 1'b1;
      end else if (fifo_pop & ~fifo_push) begin
        fifo_cnt_r <= fifo_cnt_r - 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit shifters, msb first, bits launched on bit clock rise

  reg [`DCSP_WORD_W-1:0] tx_sh0_r;
  reg [`DCSP_WORD_W-1:0] tx_sh1_r;
  reg [`DCSP_BITCNT_W-1:0] tx_cnt_r;
  reg tx_busy_r;

  assign tx_start = ext_framing ? (bclk_rise & frame_fall(fsx_q_r, fsx_s2_r)) : int_start;

  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      tx_sh0_r <= `DCSP_ZERO8;
      tx_sh1_r <= `DCSP_ZERO8;
      tx_cnt_r <= {`DCSP_BITCNT_W{1'b0}};
      tx_busy_r <= 1'b0;
      TX_DATA_OUT_CH0 <= 1'b0;
      TX_DATA_OUT_CH1 <= 1'b0;
      TX_DATA_OE_CH0 <= 1'b0;
      TX_DATA_OE_CH1 <= 1'b0;
    end else if (fifo_pop) begin
      tx_sh0_r <= {tx_holding_regs[fifo_rp_r][`DCSP_WORD_W-2:0], 1'b0};
      tx_sh1_r <= {tx_holding_regs[fifo_rp_r][`DCSP_DATA_W-2:`DCSP_WORD_W], 1'b0};
      TX_DATA_OUT_CH0 <= tx_holding_regs[fifo_rp_r][`DCSP_WORD_W-1];
      TX_DATA_OUT_CH1 <= tx_holding_regs[fifo_rp_r][`DCSP_DATA_W-1];
      TX_DATA_OE_CH0 <= 1'b1;
      TX_DATA_OE_CH1 <= 1'b1;
      tx_cnt_r <= `DCSP_BITS_PER_WORD - 1'b1;
      tx_busy_r <= 1'b1;
    end else if (bclk_rise & tx_busy_r) begin
      if (tx_cnt_r == {`DCSP_BITCNT_W{1'b0}}) begin
        tx_busy_r <= 1'b0;
        TX_DATA_OE_CH0 <= 1'b0;
        TX_DATA_OE_CH1 <= 1'b0;
      end else begin
        TX_DATA_OUT_CH0 <= tx_sh0_r[`DCSP_WORD_W-1];
        TX_DATA_OUT_CH1 <= tx_sh1_r[`DCSP_WORD_W-1];
        tx_sh0_r <= {tx_sh0_r[`DCSP_WORD_W-2:0], 1'b0};
        tx_sh1_r <= {tx_sh1_r[`DCSP_WORD_W-2:0], 1'b0};
        tx_cnt_r <= tx_cnt_r - 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive shifters, msb first, bits captured on bit clock fall

  reg [`DCSP_WORD_W-1:0] rx_shift_regs0_r;
  reg [`DCSP_WORD_W-1:0] rx_shift_regs1_r;
  reg [`DCSP_WORD_W-1:0] rx_data0_r;
  reg [`DCSP_WORD_W-1:0] rx_data1_r;
  reg [`DCSP_BITCNT_W-1:0] rx_cnt_r;
  reg rx_busy_r;
  reg rx_done;
  wire rx_start;

  assign rx_start = ext_framing ? (bclk_rise & frame_fall(fsr_q_r, fsr_s2_r)) : int_start;

  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rx_shift_regs0_r <= `DCSP_ZERO8;
      rx_shift_regs1_r <= `DCSP_ZERO8;
      rx_data0_r <= `DCSP_ZERO8;
      rx_data1_r <= `DCSP_ZERO8;
      rx_cnt_r <= {`DCSP_BITCNT_W{1'b0}};
      rx_busy_r <= 1'b0;
    end else if (rx_start) begin
      rx_cnt_r <= `DCSP_BITS_PER_WORD;
      rx_busy_r <= 1'b1;
    end else if (bclk_fall & rx_busy_r) begin
      rx_shift_regs0_r <= {rx_shift_regs0_r[`DCSP_WORD_W-2:0], dr_s2_r[0]};
      rx_shift_regs1_r <= {rx_shift_regs1_r[`DCSP_WORD_W-2:0], dr_s2_r[1]};
      rx_cnt_r <= rx_cnt_r - 1'b1;
      if (rx_cnt_r == `DCSP_RX_LAST) begin
        rx_busy_r <= 1'b0;
        rx_data0_r <= {rx_shift_regs0_r[`DCSP_WORD_W-2:0], dr_s2_r[0]};
        rx_data1_r <= {rx_shift_regs1_r[`DCSP_WORD_W-2:0], dr_s2_r[1]};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // flag events: frame end edges externally, word completion internally

  always @* begin
    rx_done = bclk_fall & rx_busy_r & (rx_cnt_r == `DCSP_RX_LAST) & ~rx_start;
    if (ext_framing) begin
      rx_flag_set = bclk_rise & frame_rise(fsr_q_r, fsr_s2_r);
      tx_flag_set = bclk_rise & frame_rise(fsx_q_r, fsx_s2_r);
    end else begin
      rx_flag_set = rx_done;
      tx_flag_set = bclk_rise & tx_busy_r & (tx_cnt_r == {`DCSP_BITCNT_W{1'b0}}) & ~fifo_pop;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data and interrupt request

  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= `DCSP_ZERO16;
      IRQ <= 1'b0;
    end else begin
      IRQ <= (rx_flag_r & ctl_lo_r[`DCSP_LO_RX_IEN]) | (tx_flag_r & ctl_lo_r[`DCSP_LO_TX_IEN]);
      RDATA <= `DCSP_ZERO16;
      if (RD_STB & (ADDR == `DCSP_PORT_CTL_LO)) begin
        RDATA <= ctl_lo_r;
        RDATA[`DCSP_LO_RX_FLAG] <= rx_flag_r;
        RDATA[`DCSP_LO_TX_FLAG] <= tx_flag_r;
        RDATA[`DCSP_LO_FIFO_FULL] <= fifo_full;
        RDATA[`DCSP_LO_FIFO_EMPTY] <= fifo_empty;
        RDATA[`DCSP_LO_TX_BUSY] <= tx_busy_r;
        RDATA[`DCSP_LO_RX_BUSY] <= rx_busy_r;
      end else if (RD_STB & (ADDR == `DCSP_PORT_CTL_HI) & hi_sel) begin
        RDATA <= ctl_hi_r;
      end else if (rd_data) begin
        RDATA <= {rx_data1_r, rx_data0_r};
      end
    end
  end

endmodule // dcsp_top

`default_nettype wire

// ==== tb/dcsp_top_properties.sv ====
// assertions on the ports of the codec serial port
`timescale 1ns/1ns
`include "dcsp_regs.vh"
`default_nettype none

module dcsp_top_properties (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // register port
  input wire logic [`DCSP_PORT_W-1:0] ADDR,
  input wire logic [`DCSP_DATA_W-1:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [`DCSP_DATA_W-1:0] RDATA,
  // serial side
  input wire logic TX_DATA_OE_CH0,
  input wire logic TX_DATA_OE_CH1,
  input wire logic INTERNAL_FRAME_PULSE,
  input wire logic BIT_CLOCK_OE,
  input wire logic IRQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  logic wr0;
  logic ext_r;

  // framing mode as last written, to tell internal starts from external ones
  assign wr0 = WR_STB && ADDR == `DCSP_PORT_CTL_LO;
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ext_r <= 1'b0;
    end else if (wr0) begin
      ext_r <= WDATA[`DCSP_LO_EXT_FRAMING];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control writes followed by a quiet cycle
  sequence s_wr_quiet;
    wr0 ##1 !wr0;
  endsequence
  sequence s_mask_quiet;
    wr0 && WDATA[`DCSP_LO_TX_IEN:`DCSP_LO_RX_IEN] == 2'h0 ##1 !wr0;
  endsequence

  property p_rdata_idle;
    !RD_STB |=> RDATA == `DCSP_ZERO16;
  endproperty
  property p_unmapped;
    RD_STB && ADDR > `DCSP_PORT_CTL_HI |=> RDATA == `DCSP_ZERO16;
  endproperty
  property p_oe_pair;
    TX_DATA_OE_CH0 == TX_DATA_OE_CH1;
  endproperty
  property p_bclk_oe;
    s_wr_quiet |=> BIT_CLOCK_OE == $past(WDATA[`DCSP_LO_BCLK_OUT], 2);
  endproperty
  property p_oe_len;
    $rose(TX_DATA_OE_CH0) |-> TX_DATA_OE_CH0 [*8];
  endproperty
  property p_start;
    $rose(TX_DATA_OE_CH0) && !ext_r |-> INTERNAL_FRAME_PULSE;
  endproperty
  property p_irq_off;
    s_mask_quiet |=> !IRQ;
  endproperty
  property p_reset_out;
    $rose(RESETN) |-> !BIT_CLOCK_OE && !TX_DATA_OE_CH0 && !IRQ && !INTERNAL_FRAME_PULSE;
  endproperty
  property p_full_empty;
    RD_STB && ADDR == `DCSP_PORT_CTL_LO |=>
      !(RDATA[`DCSP_LO_FIFO_FULL] && RDATA[`DCSP_LO_FIFO_EMPTY]);
  endproperty

  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");
  a_unmapped: assert property (p_unmapped) else $error("unmapped port read nonzero");
  a_oe_pair: assert property (p_oe_pair) else $error("channel enables differ");
  a_bclk_oe: assert property (p_bclk_oe) else $error("bit clock enable wrong");
  a_oe_len: assert property (p_oe_len) else $error("transmit word too short");
  a_start: assert property (p_start) else $error("transmit without frame pulse");
  a_irq_off: assert property (p_irq_off) else $error("masked interrupt raised");
  a_reset_out: assert property (p_reset_out) else $error("pins driven after reset");
  a_full_empty: assert property (p_full_empty) else $error("queue full and empty");
endmodule // dcsp_top_properties
`default_nettype wire

// ==== tb/dcsp_codec_model.sv ====
// behavioural codec on the far side of the serial port
`timescale 1ns/1ns
`default_nettype none

module dcsp_codec_model (
  // bit clock pin, frame pulse and external frame request
  input wire logic bclk,
  input wire logic pulse,
  input wire logic ext_req,
  // words this codec sends
  input wire logic [7:0] word0,
  input wire logic [7:0] word1,
  // transmit pins of the port
  input wire logic tx0,
  input wire logic tx1,
  input wire logic oe0,
  input wire logic oe1,
  // lines driven to the port
  output logic rx0,
  output logic rx1,
  output logic frx_n,
  output logic ftx_n,
  // words heard on the transmit pins
  output logic [7:0] cap0,
  output logic [7:0] cap1
);
  logic [7:0] sh0, sh1;
  logic hold;
  int left, rises;

  // idle: frame lines high, nothing queued
  initial begin
    rx0 = 1'b0;
    rx1 = 1'b1;
    frx_n = 1'b1;
    ftx_n = 1'b1;
    cap0 = 8'h00;
    cap1 = 8'h00;
    hold = 1'b0;
    left = 0;
    rises = 0;
  end

  // put the msb of each word on its line
  task automatic load();
    sh0 = word0;
    sh1 = word1;
    rx0 = sh0[7];
    rx1 = sh1[7];
    left = 7;
  endtask

  // internal framing: msb goes out once the frame pulse is seen
  // the msb must stand through the rise that raised the pulse
  always @(posedge pulse) begin
    load();
    hold = 1'b1;
  end

  // next bit on each rise; released lines toggle so no stale level lingers;
  // the short wait lets a pulse raised on this same rise load first
  always @(posedge bclk) begin
    #1;
    if (!frx_n) rises++;
    if (!ext_req) rises = 0;
    if (hold) begin
      hold = 1'b0;
    end else if (left > 0) begin
      sh0 = sh0 << 1;
      sh1 = sh1 << 1;
      rx0 = sh0[7];
      rx1 = sh1[7];
      left--;
    end else begin
      rx0 = ~rx0;
      rx1 = ~rx1;
    end
  end

  // capture on falls; external frames only move with a running clock
  always @(negedge bclk) begin
    if (oe0) cap0 = {cap0[6:0], tx0};
    if (oe1) cap1 = {cap1[6:0], tx1};
    if (!frx_n && rises == 8) begin
      frx_n = 1'b1;
      ftx_n = 1'b1;
    end else if (ext_req && frx_n && rises == 0) begin
      frx_n = 1'b0;
      ftx_n = 1'b0;
      load();
      hold = 1'b1;
    end
  end
endmodule // dcsp_codec_model
`default_nettype wire

// ==== tb/dual_channel_codec_serial_port_tb.sv ====
// self-checking bench for the dual channel codec serial port
`timescale 1ns/1ns
`include "dcsp_regs.vh"
`default_nettype none

module dual_channel_codec_serial_port_tb;
  logic clock, resetn, wr_stb, rd_stb, ext_req, seen;
  logic [`DCSP_PORT_W-1:0] addr;
  logic [`DCSP_DATA_W-1:0] wdata, got, hi, per;
  logic [7:0] word0, word1;
  wire [`DCSP_DATA_W-1:0] rdata;
  wire tx0, tx1, oe0, oe1, pulse, bco, bcoe, irq, rx0, rx1, frx_n, ftx_n, bclk;
  wire [7:0] cap0, cap1;
  int n_fail, n_checks, cyc;

  // clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // a released bit clock pin shows the inverse of bco, which is then held low, so it idles high
  assign bclk = bcoe ? bco : ~bco;

  dcsp_top DUT (
    .CLOCK(clock), .RESETN(resetn), .ADDR(addr), .WDATA(wdata),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
    .RX_DATA_IN_CH0(rx0), .RX_DATA_IN_CH1(rx1),
    .TX_DATA_OUT_CH0(tx0), .TX_DATA_OUT_CH1(tx1),
    .TX_DATA_OE_CH0(oe0), .TX_DATA_OE_CH1(oe1),
    .INTERNAL_FRAME_PULSE(pulse), .EXT_RX_FRAME_N(frx_n), .EXT_TX_FRAME_N(ftx_n),
    .BIT_CLOCK_IN(bclk), .BIT_CLOCK_OUT(bco), .BIT_CLOCK_OE(bcoe), .IRQ(irq)
  );
  dcsp_codec_model codec (
    .bclk(bclk), .pulse(pulse), .ext_req(ext_req), .word0(word0), .word1(word1),
    .tx0(tx0), .tx1(tx1), .oe0(oe0), .oe1(oe1), .rx0(rx0), .rx1(rx1),
    .frx_n(frx_n), .ftx_n(ftx_n), .cap0(cap0), .cap1(cap1)
  );

  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [15:0] act, input logic [15:0] exp);
    n_checks++;
    if (act !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, act, exp);
    end
  endtask
  // one-cycle write and read strobes
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // time the high phase and the period of the next frame pulse
  task automatic pulse_meas();
    int k;
    hi = 16'h0000;
    for (k = 0; k < 1000 && pulse; k++) @(posedge clock);
    for (k = 0; k < 1000 && !pulse; k++) @(posedge clock);
    for (k = 0; k < 1000 && pulse; k++) begin
      @(posedge clock);
      hi++;
    end
    per = hi;
    for (k = 0; k < 1000 && !pulse; k++) begin
      @(posedge clock);
      per++;
    end
  endtask
  // wait for one transmitted word to start and finish
  task automatic wait_word();
    int k;
    for (k = 0; k < 2000 && !oe0; k++) @(posedge clock);
    for (k = 0; k < 2000 && oe0; k++) @(posedge clock);
    repeat (16) @(posedge clock);
  endtask
  // watch the transmit enables for a while
  task automatic quiet();
    seen = 1'b0;
    repeat (300) begin
      @(posedge clock);
      seen = seen | oe0 | oe1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    int p;
    chk({15'h0000, bcoe}, 16'h0000);
    rdc(`DCSP_PORT_CTL_LO, 16'h0400);
    for (p = 2; p < 8; p++) begin
      wr(p[2:0], 16'hFFFF);
      rdc(p[2:0], 16'h0000);
    end
    wr(`DCSP_PORT_CTL_LO, 16'h0100);
    wr(`DCSP_PORT_CTL_HI, 16'h030F);
    rdc(`DCSP_PORT_CTL_HI, 16'h030F);
    rdc(`DCSP_PORT_CTL_LO, 16'h0500);
    $display("reset and register map done");
  endtask
  task automatic t_queue();
    wr(`DCSP_PORT_CTL_LO, 16'h0000);
    wr(`DCSP_PORT_CTL_HI, 16'hA53C);
    wr(`DCSP_PORT_CTL_HI, 16'h5AC3);
    wr(`DCSP_PORT_CTL_HI, 16'hFFFF);
    rdc(`DCSP_PORT_CTL_LO, 16'h0200);
    quiet();
    chk({15'h0000, seen}, 16'h0000);
    $display("queue fill without bit clock done");
  endtask
  task automatic t_internal();
    word0 = 8'h96;
    word1 = 8'h69;
    wr(`DCSP_PORT_CTL_LO, 16'h0040);
    wait_word();
    chk({cap1, cap0}, 16'hA53C);
    rdc(`DCSP_PORT_CTL_HI, 16'h6996);
    pulse_meas();
    chk(hi, 16'h0008);
    chk(per, 16'h0080);
    chk({cap1, cap0}, 16'h5AC3);
    wr(`DCSP_PORT_CTL_LO, 16'h00C0);
    pulse_meas();
    chk(hi, 16'h0040);
    chk(per, 16'h0080);
    quiet();
    chk({15'h0000, seen}, 16'h0000);
    $display("internal framing done");
  endtask
  task automatic t_external();
    word0 = 8'h81;
    word1 = 8'h7E;
    wr(`DCSP_PORT_CTL_LO, 16'h007E);
    wr(`DCSP_PORT_CTL_HI, 16'h1234);
    ext_req <= 1'b1;
    wait_word();
    ext_req <= 1'b0;
    chk({cap1, cap0}, 16'h1234);
    rdc(`DCSP_PORT_CTL_HI, 16'h7E81);
    rdc(`DCSP_PORT_CTL_LO, 16'h047E);
    chk({15'h0000, irq}, 16'h0001);
    wr(`DCSP_PORT_CTL_LO, 16'h007E);
    rdc(`DCSP_PORT_CTL_LO, 16'h0478);
    chk({15'h0000, irq}, 16'h0000);
    $display("external framing done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // verdict and hang guard
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  // main sequence
  initial begin
    resetn = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    ext_req = 1'b0;
    addr = 3'h0;
    wdata = 16'h0000;
    word0 = 8'h00;
    word1 = 8'h00;
    n_fail = 0;
    n_checks = 0;
    cyc = 0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    t_reset();
    t_queue();
    t_internal();
    t_external();
    give_verdict();
  end
endmodule // dual_channel_codec_serial_port_tb

bind dcsp_top dcsp_top_properties u_props (
  .CLOCK(CLOCK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB),
  .RD_STB(RD_STB), .RDATA(RDATA), .TX_DATA_OE_CH0(TX_DATA_OE_CH0),
  .TX_DATA_OE_CH1(TX_DATA_OE_CH1), .INTERNAL_FRAME_PULSE(INTERNAL_FRAME_PULSE),
  .BIT_CLOCK_OE(BIT_CLOCK_OE), .IRQ(IRQ)
);
`default_nettype wire
